// [rtl/ddt_top.sv]
// Deflection drive timing: line/field timing loops, horizontal drive output stage,
// field accumulator waveforms, protection, reset extension and power-down handling.
// Assumes all inputs synchronous to REF_CLK; sync/flyback/safety come from the front end.
//
// Functional notes
// [R1] Drive generator ticks at 1 MHz; output stage divides it to period and width.
// [R2] Standby clocks the stage from 5 MHz divided by five, fixed width.
// [R3] Outside standby the drive width comes from the programmed register.
// [R4] First loop makes line and field timing, locks phase and frequency to front sync.
// [R5] Second loop follows first loop, shifting drive phase for output stage delay; phase_q shifts only MAIN_SYNC here, the output stage ignores it.
// [R6] Main display sync output multiplexes display timing from second loop.
// [R7] Controller programs new-line parameter at least 34.
// [R8] Version readable; comb versions add 35 cycles; controller adjusts offsets.
// [R9] Accumulators reload initialization values each field start.
// [R10] Initialization values are 12 bits: four vertical, five east/west.
// [R11] Waveforms are polynomials up to fourth order across one field.
// [R12] Vertical amplitude may be scaled by average beam current.
// [R13] Retrace may halve vertical converter output impedance.
// [R14] Missing flyback falling edge in a field blanks RGB.
// [R15] Software option shuts off drive during flyback.
// [R16] Safety: low normal, middle blanks RGB, high blanks and stops drive.
// [R17] Internal reset extends 4 us after release, then initialization runs.
// [R18] No bus answer during initialization.
// [R19] Reset leaves dividers running; drive uses standby clock in reset.
// [R20] Standby forces 50 percent duty and disables protection.
// [R21] Drive off until 5 MHz clock seen; coupling bit selects loop clock.
// [R22] Supply dip over 50 ns gives power-down held 50 us: standby, 50 percent.
// [R23] Source change may lengthen current phase by up to one tick.
// [R24] Source switches only at a phase boundary.
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ddt_top (
  input  wire logic        REF_CLK,     // 25 MHz clock
  input  wire logic        RST_N,       // Async reset, active low
  input  wire logic        WB_CYC_I,    // Wishbone cycle
  input  wire logic        WB_STB_I,    // Wishbone strobe
  input  wire logic        WB_WE_I,     // Wishbone write
  input  wire logic [7:0]  WB_ADR_I,    // Byte address
  input  wire logic [3:0]  WB_SEL_I,    // Byte enables
  input  wire logic [31:0] WB_DAT_I,    // Write data
  output logic [31:0]      WB_DAT_O,    // Read data
  output logic             WB_ACK_O,    // Acknowledge
  input  wire logic        FRONT_SYNC,  // Front sync line pulse
  input  wire logic        FIELD_SYNC,  // Front field start pulse
  input  wire logic        FLYBACK_IN,  // Vertical flyback input
  input  wire logic [1:0]  SAFETY_LVL,  // Safety comparator result
  input  wire logic        SUPPLY_LOW,  // Digital supply below threshold
  input  wire logic [11:0] BEAM_AVG,    // Average beam current
  output logic             FIVE_MEGAHERTZ_CLOCK_OUT,    // 5 MHz clock output
  output logic             HDRIVE_O,    // Drive output level (open drain)
  output logic             HDRIVE_OE,   // Drive output enable, high pulls low
  output logic             MAIN_SYNC,   // Main display sync
  output logic             HBLANK,      // Line blanking
  output logic             RGB_BLANK,   // RGB blanked by protection
  output logic [11:0]      VERT_OUT,    // Vertical waveform
  output logic [11:0]      EW_OUT,      // East/west waveform
  output logic             VRETRACE_LOZ,// Halved converter impedance
  output logic             INIT_BUSY    // Internal reset or init running
);

  // ==========================================================================
  // Free running dividers, never reset
  // ==========================================================================
  logic [2:0] div5_q = 3'h0;
  logic [2:0] divs_q = 3'h0;
  logic       five_megahertz_clock_q = 1'b0;
  logic       stby_tick_q = 1'b0;
  wire        five_edge = (div5_q == 3'(ddt_pkg::FIVE_DIV - 1));

  always_ff @(posedge REF_CLK) begin // see [R19]
    div5_q      <= five_edge ? 3'h0 : div5_q + 3'h1;
    five_megahertz_clock_q      <= (div5_q < 3'(ddt_pkg::FIVE_DIV / 2));
    if (five_edge) begin
      divs_q <= (divs_q == 3'(ddt_pkg::STBY_DIV - 1)) ? 3'h0 : divs_q + 3'h1;
    end
    stby_tick_q <= five_edge && (divs_q == 3'h0); // see [R2]
  end
  assign FIVE_MEGAHERTZ_CLOCK_OUT = five_megahertz_clock_q;

  // ==========================================================================
  // Reset extension and initialization
  // ==========================================================================
  logic [7:0] rst_cnt_q;
  logic [6:0] init_cnt_q;
  wire        int_rst = (rst_cnt_q != 8'h00);
  wire        busy    = int_rst || (init_cnt_q != 7'h00);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_cnt_q  <= 8'(ddt_pkg::RST_EXT_CYC); // see [R17]
      init_cnt_q <= 7'(ddt_pkg::INIT_CYC);
    end else begin
      if (int_rst) rst_cnt_q <= rst_cnt_q - 8'h01;
      else if (init_cnt_q != 7'h00) init_cnt_q <= init_cnt_q - 7'h01;
    end
  end

  // ==========================================================================
  // Registers over Wishbone
  // ==========================================================================
  logic        couple_q, fbshut_q, retr_q, bcl_q, ack_q;
  logic [7:0]  drive_pulse_duration_q, phase_q;
  logic [9:0]  hper_q;
  logic [11:0] vscale_q;
  logic [11:0] coef_q [0:8];
  logic [31:0] rdat_q;
  logic        busy_q;
  logic [31:0] rd_mux;
  logic [1:0]  saf_q;
  logic        rst_lock_q, stby_q, clk_ok_q, fb_miss_q;

  // Gate on the registered busy flag so INIT_BUSY and the bus refusal agree
  wire  req    = WB_CYC_I && WB_STB_I && !ack_q && !busy_q; // see [R18]
  wire  wr     = req && WB_WE_I && WB_SEL_I[0];
  wire  [5:0] coef_off = WB_ADR_I[7:2] - ddt_pkg::A_COEF0[7:2];
  wire  [3:0] coef_idx = coef_off[3:0];
  wire  is_coef = (WB_ADR_I >= ddt_pkg::A_COEF0) && (WB_ADR_I[1:0] == 2'b00)
                  && (coef_off < 6'(ddt_pkg::COEF_N));

  function automatic logic [11:0] lo12(input logic [11:0] old, input logic [31:0] d, input logic [3:0] s);
    lo12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : lo12

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (WB_ADR_I)
      ddt_pkg::A_CTRL:    rd_mux = {28'h0, bcl_q, retr_q, fbshut_q, couple_q};
      ddt_pkg::A_DRIVE_PULSE_DURATION:    rd_mux = {24'h0, drive_pulse_duration_q};
      ddt_pkg::A_HPER:    rd_mux = {22'h0, hper_q};
      ddt_pkg::A_PHASE:   rd_mux = {24'h0, phase_q};
      ddt_pkg::A_STATUS:  rd_mux = {26'h0, rst_lock_q, stby_q, clk_ok_q, fb_miss_q, saf_q};
      ddt_pkg::A_VERSION: rd_mux = ddt_pkg::VERSION_VAL; // see [R8]
      ddt_pkg::A_VSCALE:  rd_mux = {20'h0, vscale_q};
      default:            rd_mux = is_coef ? {20'h0, coef_q[coef_idx]} : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0; rdat_q <= 32'h0000_0000;
      couple_q <= 1'b0; fbshut_q <= 1'b0; retr_q <= 1'b0; bcl_q <= 1'b0;
      drive_pulse_duration_q <= 8'h20; hper_q <= 10'h040; phase_q <= 8'h00; vscale_q <= 12'h800;
      for (int i = 0; i < 9; i++) coef_q[i] <= 12'h000;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? rd_mux : rdat_q;
      if (wr) begin
        case (WB_ADR_I)
          ddt_pkg::A_CTRL: begin
            couple_q <= WB_DAT_I[ddt_pkg::C_COUPLE]; // see [R21]
            fbshut_q <= WB_DAT_I[ddt_pkg::C_FBSHUT]; // see [R15]
            retr_q   <= WB_DAT_I[ddt_pkg::C_RETRACE];
            bcl_q    <= WB_DAT_I[ddt_pkg::C_BCLSCALE];
          end
          ddt_pkg::A_DRIVE_PULSE_DURATION:   drive_pulse_duration_q   <= WB_DAT_I[7:0];
          ddt_pkg::A_HPER:   hper_q   <= 10'(lo12({2'b00, hper_q}, WB_DAT_I, WB_SEL_I));
          ddt_pkg::A_PHASE:  phase_q  <= WB_DAT_I[7:0];
          ddt_pkg::A_VSCALE: vscale_q <= lo12(vscale_q, WB_DAT_I, WB_SEL_I);
          default: if (is_coef) coef_q[coef_idx] <= lo12(coef_q[coef_idx], WB_DAT_I, WB_SEL_I); // see [R10]
        endcase
      end
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ==========================================================================
  // First loop: line counter locked to front sync, 1 MHz timing tick
  // ==========================================================================
  logic [4:0] tdiv_q;
  logic [9:0] line_q, per_q;
  logic       loop_tick_q, hblank_q;
  wire        tick_edge = (tdiv_q == 5'(ddt_pkg::TICK_DIV - 1));
  wire        line_end  = tick_edge && (line_q >= per_q - 10'h001);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tdiv_q <= 5'h00; line_q <= 10'h000; per_q <= 10'h040;
      loop_tick_q <= 1'b0; rst_lock_q <= 1'b0; hblank_q <= 1'b0;
    end else begin
      tdiv_q      <= tick_edge ? 5'h00 : tdiv_q + 5'h01; // see [R1]
      loop_tick_q <= tick_edge;
      if (FRONT_SYNC) begin // see [R4]
        per_q      <= (line_q > (hper_q >> 1)) ? line_q + 10'h001 : hper_q;
        rst_lock_q <= (line_q == per_q - 10'h001) || (line_q == 10'h000);
        line_q     <= 10'h000;
        tdiv_q     <= 5'h00;
      end else if (line_end) line_q <= 10'h000;
      else if (tick_edge) line_q <= line_q + 10'h001;
      hblank_q <= (line_q < 10'(drive_pulse_duration_q)) ? 1'b1 : 1'b0;
    end
  end
  assign HBLANK = hblank_q;

  // ==========================================================================
  // Second loop: delayed line start, main sync, clock supervision, standby
  // ==========================================================================
  logic       msync_q, pd_q, sup_prev_q;
  logic [3:0] clk_cnt_q;
  logic [1:0] dip_q;
  logic [10:0] pd_cnt_q;
  logic       prev_five_megahertz_clock_q;
  wire  drive_start = loop_tick_q && (line_q == 10'(phase_q)); // see [R5]

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      msync_q <= 1'b0; clk_ok_q <= 1'b0; clk_cnt_q <= 4'h0; prev_five_megahertz_clock_q <= 1'b0;
      dip_q <= 2'h0; pd_cnt_q <= 11'h000; pd_q <= 1'b0; sup_prev_q <= 1'b0;
    end else begin
      msync_q     <= drive_start || (FIELD_SYNC && hblank_q); // see [R6]
      prev_five_megahertz_clock_q <= five_megahertz_clock_q;
      if (five_megahertz_clock_q && !prev_five_megahertz_clock_q && clk_cnt_q != 4'(ddt_pkg::CLK_OK_TICKS)) clk_cnt_q <= clk_cnt_q + 4'h1;
      clk_ok_q    <= (clk_cnt_q == 4'(ddt_pkg::CLK_OK_TICKS)); // see [R21]
      dip_q       <= SUPPLY_LOW ? ((dip_q == 2'(ddt_pkg::DIP_CYC)) ? dip_q : dip_q + 2'h1) : 2'h0;
      if (dip_q == 2'(ddt_pkg::DIP_CYC)) begin // see [R22]
        pd_q <= 1'b1; pd_cnt_q <= 11'(ddt_pkg::PD_HOLD_CYC);
      end else if (pd_cnt_q != 11'h000) pd_cnt_q <= pd_cnt_q - 11'h001;
      else pd_q <= 1'b0;
      sup_prev_q <= SUPPLY_LOW;
    end
  end
  assign MAIN_SYNC = msync_q;
  wire  want_stby = int_rst || pd_q || !couple_q; // see [R19] [R22]

  // ==========================================================================
  // Horizontal output stage
  // ==========================================================================
  logic [9:0] ph_cnt_q;
  logic       horizontal_drive_output_q, oe_q;
  wire  src_tick  = stby_q ? stby_tick_q : loop_tick_q;
  wire  [9:0] per_len = stby_q ? per_q : per_q;
  wire  [9:0] low_len = stby_q ? (per_len >> 1) : 10'(drive_pulse_duration_q); // see [R2] [R3] [R20]
  wire  [9:0] ph_len  = horizontal_drive_output_q ? (per_len - low_len) : low_len;
  wire  boundary = src_tick && (ph_cnt_q >= ph_len - 10'h001);
  wire  prot_on  = !stby_q;
  wire  shut = prot_on && ((saf_q == ddt_pkg::SAF_SHUT) || (fbshut_q && FLYBACK_IN)); // see [R15] [R16]

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stby_q <= 1'b1; ph_cnt_q <= 10'h000; horizontal_drive_output_q <= 1'b1; oe_q <= 1'b0;
    end else begin
      if (boundary) begin
        ph_cnt_q <= 10'h000;
        horizontal_drive_output_q   <= !horizontal_drive_output_q;
        stby_q   <= want_stby; // see [R23] [R24]
      end else if (src_tick) ph_cnt_q <= ph_cnt_q + 10'h001;
      oe_q <= clk_ok_q && !shut && boundary ? horizontal_drive_output_q : (clk_ok_q && !shut && oe_q);
    end
  end
  assign HDRIVE_O  = 1'b0;
  assign HDRIVE_OE = oe_q;

  // ==========================================================================
  // Protection: flyback watch and safety levels
  // ==========================================================================
  logic       fb_prev_q, fb_seen_q, rgbb_q;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      saf_q <= ddt_pkg::SAF_OK; fb_prev_q <= 1'b0; fb_seen_q <= 1'b0; fb_miss_q <= 1'b0; rgbb_q <= 1'b0;
    end else begin
      saf_q     <= SAFETY_LVL;
      fb_prev_q <= FLYBACK_IN;
      if (FIELD_SYNC) begin // see [R14]
        fb_miss_q <= !fb_seen_q && !(fb_prev_q && !FLYBACK_IN);
        fb_seen_q <= 1'b0;
      end else if (fb_prev_q && !FLYBACK_IN) fb_seen_q <= 1'b1;
      rgbb_q <= prot_on && (fb_miss_q || saf_q != ddt_pkg::SAF_OK); // see [R16] [R20]
    end
  end
  assign RGB_BLANK = rgbb_q;

  // ==========================================================================
  // Field waveforms: accumulator chains reloaded each field
  // ==========================================================================
  logic [11:0] vacc_q [0:3];
  logic [11:0] eacc_q [0:4];
  logic [11:0] vout_q, eout_q;
  logic        vretr_q;
  wire  [23:0] vprod = (bcl_q ? BEAM_AVG : vscale_q) * vacc_q[0];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) vacc_q[i] <= 12'h000;
      for (int i = 0; i < 5; i++) eacc_q[i] <= 12'h000;
      vout_q <= 12'h000; eout_q <= 12'h000; vretr_q <= 1'b0;
    end else begin
      if (FIELD_SYNC) begin // see [R9]
        for (int i = 0; i < 4; i++) vacc_q[i] <= coef_q[i];
        for (int i = 0; i < 5; i++) eacc_q[i] <= coef_q[4 + i];
      end else if (line_end) begin // see [R11]
        for (int i = 0; i < 3; i++) vacc_q[i] <= vacc_q[i] + vacc_q[i + 1];
        for (int i = 0; i < 4; i++) eacc_q[i] <= eacc_q[i] + eacc_q[i + 1];
      end
      vout_q  <= vprod[22:11]; // see [R12]
      eout_q  <= eacc_q[0];
      vretr_q <= retr_q && FLYBACK_IN; // see [R13]
    end
  end
  assign VERT_OUT     = vout_q;
  assign EW_OUT       = eout_q;
  assign VRETRACE_LOZ = vretr_q;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) busy_q <= 1'b1;
    else busy_q <= busy;
  end
  assign INIT_BUSY = busy_q;

endmodule : ddt_top

// [pkg/ddt_pkg.sv]
// Package for the deflection drive timing block: register map, timing constants, carrier types.
// Assumes a 25 MHz REF_CLK and a classic Wishbone slave with 32-bit data.
package ddt_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_HZ           = 25000000;
  localparam int TICK_HZ          = 1000000;
  localparam int TICK_DIV         = CLK_HZ / TICK_HZ;
  localparam int FIVE_HZ          = 5000000;
  localparam int FIVE_DIV         = CLK_HZ / FIVE_HZ;
  localparam int STBY_DIV         = FIVE_HZ / TICK_HZ;
  localparam int RST_EXT_NS       = 4000;
  localparam int RST_EXT_CYC      = (RST_EXT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DIP_NS           = 50;
  localparam int DIP_CYC_RAW      = (DIP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DIP_CYC          = (DIP_CYC_RAW < 1) ? 1 : DIP_CYC_RAW;
  localparam int PD_HOLD_US       = 50;
  localparam int PD_HOLD_CYC      = PD_HOLD_US * (CLK_HZ / 1000000);
  localparam int INIT_CYC         = 64;
  localparam int CLK_OK_TICKS     = 8;
  localparam int NEW_LINE_PARAMETER_MIN       = 34;
  localparam int COMB_DELAY       = 35;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_DRIVE_PULSE_DURATION    = 8'h04;
  localparam logic [7:0] A_HPER    = 8'h08;
  localparam logic [7:0] A_PHASE   = 8'h0C;
  localparam logic [7:0] A_STATUS  = 8'h10;
  localparam logic [7:0] A_VERSION = 8'h14;
  localparam logic [7:0] A_VSCALE  = 8'h18;
  localparam logic [7:0] A_COEF0   = 8'h20;
  localparam logic [3:0] COEF_N    = 4'h9;

  // CTRL fields
  localparam int C_COUPLE   = 0;
  localparam int C_FBSHUT   = 1;
  localparam int C_RETRACE  = 2;
  localparam int C_BCLSCALE = 3;
  localparam logic [31:0] VERSION_VAL = 32'h0000_00F1; // Arbitrary version code

  // Safety levels
  typedef enum logic [1:0] {
    SAF_OK    = 2'b00,
    SAF_BLANK = 2'b01,
    SAF_SHUT  = 2'b10
  } ddt_saf_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ddt_wb_req_t;

  typedef struct packed {
    logic        rgb_blank;
    logic        drive_off;
    logic        stby_sel;
  } ddt_prot_t;

endpackage : ddt_pkg

// [verification/ddt_top_monitor.sv]
// Checker for ddt_top: bus handshake, init timing, 5 MHz output and drive enable.
// Assumes it is bound onto ddt_top and sees only its ports.
`timescale 1ns/1ps
module ddt_top_monitor (
  input wire logic        REF_CLK,   // Clock
  input wire logic        RST_N,     // Reset, active low
  input wire logic        WB_CYC_I,  // Bus cycle
  input wire logic        WB_STB_I,  // Bus strobe
  input wire logic [31:0] WB_DAT_O,  // Read data
  input wire logic        WB_ACK_O,  // Acknowledge
  input wire logic        FIVE_MEGAHERTZ_CLOCK_OUT,  // 5 MHz output
  input wire logic        HDRIVE_OE, // Drive enable
  input wire logic        MAIN_SYNC, // Main sync
  input wire logic        INIT_BUSY  // Init running
);
  logic [7:0] rel_q;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Cycles since reset release, saturating
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) rel_q <= 8'h00;
    else if (rel_q != 8'hFF) rel_q <= rel_q + 8'h01;
  end
  property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_pulse:
    assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer; WB_CYC_I && WB_STB_I && !WB_ACK_O && !INIT_BUSY |=> WB_ACK_O; endproperty
  a_ack_answer:
    assert property (p_ack_answer) else $error("request not answered next cycle");
  property p_busy_quiet; INIT_BUSY |=> !WB_ACK_O; endproperty
  a_busy_quiet:
    assert property (p_busy_quiet) else $error("bus answered during init");
  property p_init_len; $fell(INIT_BUSY) |-> rel_q >= ddt_pkg::RST_EXT_CYC; endproperty
  a_init_len:
    assert property (p_init_len) else $error("internal reset too short");
  property p_five_megahertz_clock; $rose(FIVE_MEGAHERTZ_CLOCK_OUT) |=> !$rose(FIVE_MEGAHERTZ_CLOCK_OUT) [*4] ##1 $rose(FIVE_MEGAHERTZ_CLOCK_OUT); endproperty
  a_five_megahertz_clock:
    assert property (p_five_megahertz_clock) else $error("5 MHz output period wrong");
  property p_oe_hold; $rose(RST_N) |-> !HDRIVE_OE [*8]; endproperty
  a_oe_hold:
    assert property (p_oe_hold) else $error("drive enabled before clock check");
  property p_msy; MAIN_SYNC |=> !MAIN_SYNC; endproperty
  a_msy:
    assert property (p_msy) else $error("main sync not a pulse");
  property p_rdata; !WB_ACK_O |-> $stable(WB_DAT_O); endproperty
  a_rdata:
    assert property (p_rdata) else $error("read data changed without ack");
endmodule : ddt_top_monitor

bind ddt_top ddt_top_monitor ddt_top_monitor_i (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FIVE_MEGAHERTZ_CLOCK_OUT(FIVE_MEGAHERTZ_CLOCK_OUT),
  .HDRIVE_OE(HDRIVE_OE), .MAIN_SYNC(MAIN_SYNC), .INIT_BUSY(INIT_BUSY));

// [verification/ddt_stage_model.sv]
// Model of the output stages: open-drain drive pin with pull-up, and flyback source.
// Assumes flyback pulses start at the bench's field pulse.
`timescale 1ns/1ps
module ddt_stage_model (
  input  wire logic   clk,      // Reference clock
  input  wire logic   rst_n,    // Reset, active low
  input  wire logic   drive_oe, // Device drives the pin
  input  wire logic   drive_o,  // Level when driven
  input  wire logic   field_go, // Field start pulse
  input  wire logic   fly_en,   // Flyback pulses produced
  output logic        flyback,  // Vertical flyback level
  output logic [15:0] lo_len,   // Last low phase, cycles
  output logic [15:0] hi_len    // Last high phase, cycles
);
  logic        pin;
  logic        pin_q;
  logic [15:0] run_q;
  logic [10:0] fly_q;
  assign pin = drive_oe ? drive_o : 1'b1; // Released pin sits at the pull-up
  assign flyback = fly_q != 11'h000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b1;
      run_q <= 16'h0000;
      fly_q <= 11'h000;
    end else begin
      pin_q <= pin;
      run_q <= (pin != pin_q) ? 16'h0001 : run_q + 16'h0001;
      if (pin != pin_q && pin_q) hi_len <= run_q;
      if (pin != pin_q && !pin_q) lo_len <= run_q;
      // Flyback longer than a line so it overlaps every drive phase
      fly_q <= (field_go && fly_en) ? 11'h6A4 : (flyback ? fly_q - 11'h001 : 11'h000);
    end
  end
endmodule : ddt_stage_model

// [verification/deflection_drive_timing_tb_top.sv]
// Testbench top: register access, drive timing, protection and flyback tests.
// Assumes ddt_top, ddt_stage_model and the bound checker; 25 MHz clock.
`timescale 1ns/1ps
module deflection_drive_timing_tb_top;
  localparam int LINE = 1600; // 64 ticks, the reset line period
  localparam int FIELD = 4 * LINE;
  ddt_pkg::ddt_wb_req_t wb = '0;
  logic        clk, ack, busy, oe, drv, blank, flyback;
  logic        rst_n = 1'b0, front_sync = 1'b0, field_sync = 1'b0, fly_en = 1'b1;
  logic [1:0]  saf = ddt_pkg::SAF_OK;
  logic [31:0] rdat, q;
  logic [15:0] lo_len, hi_len;
  logic [7:0]  ra [4] = '{ddt_pkg::A_CTRL, ddt_pkg::A_DRIVE_PULSE_DURATION, ddt_pkg::A_HPER, 8'hFC};
  logic [31:0] rv [4] = '{32'h0, 32'h20, 32'h40, 32'h0};
  int          failures = 0, n_tests = 0, cyc_cnt = 0, lc = 0, rel_cnt = 0, hits = 0;

  ddt_top ddt_top_i (
    .REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(wb.cyc), .WB_STB_I(wb.stb), .WB_WE_I(wb.we),
    .WB_ADR_I(wb.adr), .WB_SEL_I(wb.sel), .WB_DAT_I(wb.dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .FRONT_SYNC(front_sync), .FIELD_SYNC(field_sync), .FLYBACK_IN(flyback), .SAFETY_LVL(saf),
    .SUPPLY_LOW(1'b0), .BEAM_AVG(12'h800), .FIVE_MEGAHERTZ_CLOCK_OUT(), .HDRIVE_O(drv), .HDRIVE_OE(oe),
    .MAIN_SYNC(), .HBLANK(), .RGB_BLANK(blank), .VERT_OUT(), .EW_OUT(), .VRETRACE_LOZ(),
    .INIT_BUSY(busy));
  ddt_stage_model ddt_stage_model_i (
    .clk(clk), .rst_n(rst_n), .drive_oe(oe), .drive_o(drv), .field_go(field_sync),
    .fly_en(fly_en), .flyback(flyback), .lo_len(lo_len), .hi_len(hi_len));

  // ==========================================================================
  // Clock, sync pulses, timeout
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    lc <= (lc == FIELD - 1) ? 0 : lc + 1;
    front_sync <= (lc % LINE) == 0;
    field_sync <= lc == 0;
    rel_cnt <= (rst_n && busy) ? rel_cnt + 1 : rel_cnt;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 95000) begin
      failures++;
      $display("[FAIL] run length expected below 95000 seen %0d", cyc_cnt);
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 400);
    r = rdat;
    wb <= '0;
    if (n >= 400) chk("bus answer", 32'h1, 32'h0);
  endtask : xfer
  function automatic logic [31:0] near(input logic [15:0] v, input int t);
    return (v >= t - ddt_pkg::TICK_DIV && v <= t + ddt_pkg::TICK_DIV) ? 32'h1 : 32'h0;
  endfunction : near
  task automatic watch(input int n, input logic fly_only);
    hits = 0;
    repeat (n) begin
      @(posedge clk);
      if (oe !== 1'b0 && (flyback || !fly_only)) hits++;
    end
  endtask : watch
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, ddt_pkg::A_VERSION, 32'h0, q); // Issued while init still runs
    chk("version", ddt_pkg::VERSION_VAL, q);
    chk("busy at answer", 32'h0, {31'h0, busy});
    chk("init length", 32'h1, (rel_cnt >= ddt_pkg::RST_EXT_CYC) ? 32'h1 : 32'h0);
    xfer(1'b1, 8'hFC, 32'hFFFF_FFFF, q);
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 32'h0, q);
      chk("reset value", rv[i], q);
    end
    for (int i = 0; i < int'(ddt_pkg::COEF_N); i++) begin
      xfer(1'b1, ddt_pkg::A_COEF0 + 8'(4 * i), 32'hFFFF_FA50 + i, q);
      xfer(1'b0, ddt_pkg::A_COEF0 + 8'(4 * i), 32'h0, q);
      chk("coefficient", 32'h0000_0A50 + i, q);
    end
    $display("test registers done");
    repeat (3 * LINE) @(posedge clk);
    chk("standby low", 32'h1, near(lo_len, LINE / 2));
    chk("standby high", 32'h1, near(hi_len, LINE / 2));
    saf <= ddt_pkg::SAF_SHUT;
    repeat (LINE) @(posedge clk);
    chk("standby ignores safety", 32'h0, {31'h0, blank});
    chk("standby drive runs", 32'h1, near(lo_len, LINE / 2));
    saf <= ddt_pkg::SAF_OK;
    $display("test standby done");
    xfer(1'b1, ddt_pkg::A_DRIVE_PULSE_DURATION, 32'h8, q);
    xfer(1'b1, ddt_pkg::A_CTRL, 32'h1, q);
    repeat (6 * LINE) @(posedge clk);
    chk("drive width", 32'h1, near(lo_len, 200) | near(hi_len, 200));
    chk("line period", 32'h1, near(lo_len + hi_len, LINE));
    $display("test coupled drive done");
    saf <= ddt_pkg::SAF_BLANK;
    repeat (50) @(posedge clk);
    chk("safety blank", 32'h1, {31'h0, blank});
    chk("safety keeps drive", 32'h1, near(lo_len + hi_len, LINE));
    saf <= ddt_pkg::SAF_SHUT;
    repeat (50) @(posedge clk);
    watch(2 * LINE, 1'b0);
    chk("drive shut", 32'h0, 32'(hits));
    chk("shut blank", 32'h1, {31'h0, blank});
    saf <= ddt_pkg::SAF_OK;
    repeat (4 * LINE) @(posedge clk);
    chk("safety clear", 32'h0, {31'h0, blank});
    $display("test safety done");
    watch(FIELD, 1'b1);
    chk("drive in flyback", 32'h1, (hits > 2) ? 32'h1 : 32'h0);
    xfer(1'b1, ddt_pkg::A_CTRL, 32'h3, q);
    watch(FIELD, 1'b1);
    chk("flyback shutoff", 32'h1, (hits <= 2) ? 32'h1 : 32'h0);
    xfer(1'b1, ddt_pkg::A_CTRL, 32'h1, q);
    fly_en <= 1'b0;
    repeat (2 * FIELD) @(posedge clk);
    chk("missing flyback", 32'h1, {31'h0, blank});
    fly_en <= 1'b1;
    repeat (2 * FIELD) @(posedge clk);
    chk("flyback restored", 32'h0, {31'h0, blank});
    $display("test flyback done");
    tally_and_finish();
  end
endmodule : deflection_drive_timing_tb_top
